// File: hdl/cel_pkg.sv
package cel_pkg;

    // Register byte offsets, one aligned 32-bit word each
    localparam logic [7:0] OFF_LOOKUP = 8'h00;
    localparam logic [7:0] OFF_CTRL   = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_FID_A  = 8'h0C;
    localparam logic [7:0] OFF_FID_B  = 8'h10;
    localparam logic [7:0] OFF_MASK_A = 8'h14;
    localparam logic [7:0] OFF_MASK_B = 8'h18;

    // Control register bits
    localparam int CTRL_FIFO_MODE_BIT  = 0;
    localparam int CTRL_IEN_ERR_BIT    = 1;
    localparam int CTRL_IEN_PASSIVE_BIT = 2;
    localparam int CTRL_IEN_BUSOFF_BIT = 3;
    localparam int CTRL_SOFT_RST_BIT   = 4;
    localparam int CTRL_W              = 4;

    // Status register fields
    localparam int ST_ACTIVE_BIT  = 0;
    localparam int ST_PASSIVE_BIT = 1;
    localparam int ST_BUSOFF_BIT  = 2;
    localparam int ST_TEC_LSB     = 8;
    localparam int ST_REC_LSB     = 24;

    // Identifier compare word fields
    localparam int ID_W        = 29;
    localparam int FID_IDE_BIT = 29;
    localparam int FID_RTR_BIT = 30;
    localparam int FID_W       = 31;

    // Lookup unit layout: stored standard identifier sits in bits 15:5
    localparam int LOOKUP_W       = 16;
    localparam int LOOKUP_SID_LSB = 5;
    localparam int LOOKUP_IDX_LSB = 8;
    localparam int BYTE_W         = 8;

    // Error confinement counts
    localparam int TEC_W = 9;
    localparam int REC_W = 8;
    localparam int RCV_W = 8;
    localparam logic [TEC_W-1:0] TEC_PASSIVE  = 9'h080;
    localparam logic [TEC_W-1:0] TEC_BUSOFF   = 9'h0FF;
    localparam logic [REC_W-1:0] REC_PASSIVE  = 8'h80;
    localparam logic [REC_W-1:0] REC_MAX      = 8'hFF;
    localparam logic [RCV_W-1:0] RCV_LAST     = 8'h7F;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CEL_ERR_ACTIVE  = 2'b00,
        CEL_ERR_PASSIVE = 2'b01,
        CEL_BUS_OFF     = 2'b10
    } cel_err_state_type;

    // One-cycle events from the bit-level protocol engine
    typedef struct packed {
        logic tx_err;
        logic rx_err;
        logic tx_ok;
        logic rx_ok;
        logic recessive11;
    } cel_bus_evt_type;

    // Identifier of a frame just received, one-cycle valid
    typedef struct packed {
        logic            valid;
        logic            ide;
        logic            rtr;
        logic [ID_W-1:0] id;
    } cel_rx_id_type;

    // Byte-lane merge for a register write
    function automatic logic [31:0] merge_strb(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_strb

    // Filter hit: a mask bit of zero ignores that identifier bit
    function automatic logic id_hit(input cel_rx_id_type     rx,
                                    input logic [FID_W-1:0] cmp,
                                    input logic [ID_W-1:0]  mask);
        return (rx.ide == cmp[FID_IDE_BIT]) &&
               (rx.rtr == cmp[FID_RTR_BIT]) &&
               (((rx.id ^ cmp[ID_W-1:0]) & mask) == '0);
    endfunction : id_hit

    function automatic logic addr_known(input logic [7:0] addr);
        return (addr == OFF_LOOKUP) || (addr == OFF_CTRL) ||
               (addr == OFF_STATUS) || (addr == OFF_FID_A) ||
               (addr == OFF_FID_B)  || (addr == OFF_MASK_A) ||
               (addr == OFF_MASK_B);
    endfunction : addr_known

endpackage : cel_pkg

// File: hdl/cel_top.sv
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module cel_top (
    input  wire logic                   ref_clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic [7:0]             s_axi_awaddr_in,
    input  wire logic                   s_axi_awvalid_in,
    output logic                        s_axi_awready_out,
    input  wire logic [31:0]            s_axi_wdata_in,
    input  wire logic [3:0]             s_axi_wstrb_in,
    input  wire logic                   s_axi_wvalid_in,
    output logic                        s_axi_wready_out,
    output logic [1:0]                  s_axi_bresp_out,
    output logic                        s_axi_bvalid_out,
    input  wire logic                   s_axi_bready_in,
    input  wire logic [7:0]             s_axi_araddr_in,
    input  wire logic                   s_axi_arvalid_in,
    output logic                        s_axi_arready_out,
    output logic [31:0]                 s_axi_rdata_out,
    output logic [1:0]                  s_axi_rresp_out,
    output logic                        s_axi_rvalid_out,
    input  wire logic                   s_axi_rready_in,
    input  wire cel_pkg::cel_bus_evt_type bus_evt_in,
    input  wire cel_pkg::cel_rx_id_type   rx_id_in,
    output logic                        err_flag_req_out,
    output logic                        err_flag_active_out,
    output logic                        retransmit_req_out,
    output logic                        tx_enable_out,
    output logic                        rx_enable_out,
    output logic                        irq_bus_err_out,
    output logic                        irq_passive_out,
    output logic                        irq_busoff_out,
    output logic                        fifo_accept_out
);

    logic                          aw_got_reg;
    logic [7:0]                    awaddr_reg;
    logic                          w_got_reg;
    logic [31:0]                   wdata_reg;
    logic [3:0]                    wstrb_reg;
    logic                          do_write;
    logic [cel_pkg::LOOKUP_W-1:0]  lookup_reg;
    logic [cel_pkg::CTRL_W-1:0]    ctrl_reg;
    logic                          sreset_reg;
    logic [cel_pkg::FID_W-1:0]     fid_a_reg;
    logic [cel_pkg::FID_W-1:0]     fid_b_reg;
    logic [cel_pkg::ID_W-1:0]      mask_a_reg;
    logic [cel_pkg::ID_W-1:0]      mask_b_reg;
    logic [31:0]                   rd_word;
    logic [31:0]                   wr_word;
    logic [cel_pkg::TEC_W-1:0]     tec_reg;
    logic [cel_pkg::TEC_W-1:0]     tec_next;
    logic [cel_pkg::REC_W-1:0]     rec_reg;
    logic [cel_pkg::REC_W-1:0]     rec_next;
    logic [cel_pkg::RCV_W-1:0]     rcv_reg;
    logic [cel_pkg::RCV_W-1:0]     rcv_next;
    cel_pkg::cel_err_state_type    state_reg;
    cel_pkg::cel_err_state_type    state_next;
    logic                          bus_err;
    logic                          live;

    assign do_write = aw_got_reg && w_got_reg && !s_axi_bvalid_out;
    assign wr_word  = cel_pkg::merge_strb(rd_word, wdata_reg, wstrb_reg);
    assign bus_err  = bus_evt_in.tx_err || bus_evt_in.rx_err;
    assign live     = (state_reg != cel_pkg::CEL_BUS_OFF) && !sreset_reg;

    // Write address channel; ready stays low until the response is taken
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_awready_out <= 1'b1;
            aw_got_reg        <= 1'b0;
            awaddr_reg        <= 8'h00;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_got_reg        <= 1'b1;
                awaddr_reg        <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (do_write) begin
                aw_got_reg <= 1'b0;
            end
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_awready_out <= 1'b1;
            end
        end
    end

    // Write data channel, taken independently of the address
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_wready_out <= 1'b1;
            w_got_reg        <= 1'b0;
            wdata_reg        <= 32'h0000_0000;
            wstrb_reg        <= 4'h0;
        end else begin
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_got_reg        <= 1'b1;
                wdata_reg        <= s_axi_wdata_in;
                wstrb_reg        <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'b0;
            end
            if (do_write) begin
                w_got_reg <= 1'b0;
            end
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_wready_out <= 1'b1;
            end
        end
    end

    // Write response, one cycle after both halves are held
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= cel_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= cel_pkg::addr_known(awaddr_reg) ?
                                cel_pkg::RESP_OKAY : cel_pkg::RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // Read-modify view of the addressed register, shared by strobes
    always_comb begin
        rd_word = 32'h0000_0000;
        case (do_write ? awaddr_reg : s_axi_araddr_in)
            cel_pkg::OFF_LOOKUP: begin
                // Reads return the lookup form, not the stored word
                rd_word[cel_pkg::BYTE_W-1:0] =
                    lookup_reg[cel_pkg::LOOKUP_W-1:cel_pkg::LOOKUP_IDX_LSB];
                rd_word[cel_pkg::LOOKUP_IDX_LSB +: cel_pkg::BYTE_W] =
                    8'h01 << lookup_reg[cel_pkg::LOOKUP_SID_LSB +: 3];
                if (do_write) begin
                    rd_word[cel_pkg::LOOKUP_W-1:0] = lookup_reg;
                end
            end
            cel_pkg::OFF_CTRL: begin
                rd_word[cel_pkg::CTRL_W-1:0] = ctrl_reg;
            end
            cel_pkg::OFF_STATUS: begin
                // Error state flags with both counters
                rd_word[cel_pkg::ST_ACTIVE_BIT] =
                    (state_reg == cel_pkg::CEL_ERR_ACTIVE);
                rd_word[cel_pkg::ST_PASSIVE_BIT] =
                    (state_reg == cel_pkg::CEL_ERR_PASSIVE);
                rd_word[cel_pkg::ST_BUSOFF_BIT] =
                    (state_reg == cel_pkg::CEL_BUS_OFF);
                rd_word[cel_pkg::ST_TEC_LSB +: cel_pkg::TEC_W] = tec_reg;
                rd_word[cel_pkg::ST_REC_LSB +: cel_pkg::REC_W] = rec_reg;
            end
            cel_pkg::OFF_FID_A:  rd_word[cel_pkg::FID_W-1:0] = fid_a_reg;
            cel_pkg::OFF_FID_B:  rd_word[cel_pkg::FID_W-1:0] = fid_b_reg;
            cel_pkg::OFF_MASK_A: rd_word[cel_pkg::ID_W-1:0]  = mask_a_reg;
            cel_pkg::OFF_MASK_B: rd_word[cel_pkg::ID_W-1:0]  = mask_b_reg;
            default:             rd_word = 32'h0000_0000;
        endcase
    end

    // Register file; status is read-only and writes to it are dropped
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lookup_reg <= '0;
            ctrl_reg   <= '0;
            sreset_reg <= 1'b0;
            fid_a_reg  <= '0;
            fid_b_reg  <= '0;
            mask_a_reg <= '0;
            mask_b_reg <= '0;
        end else begin
            sreset_reg <= 1'b0;
            if (do_write) begin
                case (awaddr_reg)
                    cel_pkg::OFF_LOOKUP: begin
                        lookup_reg <= wr_word[cel_pkg::LOOKUP_W-1:0];
                    end
                    cel_pkg::OFF_CTRL: begin
                        ctrl_reg   <= wr_word[cel_pkg::CTRL_W-1:0];
                        // Self-clearing: restarts error confinement
                        sreset_reg <= wr_word[cel_pkg::CTRL_SOFT_RST_BIT];
                    end
                    // Extended form uses all 29 bits
                    cel_pkg::OFF_FID_A:  fid_a_reg  <= wr_word[cel_pkg::FID_W-1:0];
                    cel_pkg::OFF_FID_B:  fid_b_reg  <= wr_word[cel_pkg::FID_W-1:0];
                    cel_pkg::OFF_MASK_A: mask_a_reg <= wr_word[cel_pkg::ID_W-1:0];
                    cel_pkg::OFF_MASK_B: mask_b_reg <= wr_word[cel_pkg::ID_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // Read channel; data registered at the address handshake
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= cel_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out && !do_write) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rdata_out   <= rd_word;
            s_axi_rresp_out   <= cel_pkg::addr_known(s_axi_araddr_in) ?
                                 cel_pkg::RESP_OKAY : cel_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out  <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end

    // Counter arithmetic; an error wins over a success in the same cycle
    always_comb begin
        tec_next = tec_reg;
        rec_next = rec_reg;
        rcv_next = rcv_reg;
        if (sreset_reg) begin
            tec_next = '0;
            rec_next = '0;
            rcv_next = '0;
        end else if (state_reg == cel_pkg::CEL_BUS_OFF) begin
            if (bus_evt_in.recessive11) begin
                if (rcv_reg == cel_pkg::RCV_LAST) begin
                    tec_next = '0;
                    rec_next = '0;
                    rcv_next = '0;
                end else begin
                    rcv_next = rcv_reg + 1'b1;
                end
            end
        end else begin
            if (bus_evt_in.tx_err) begin
                tec_next = tec_reg + 1'b1;
            end else if (bus_evt_in.tx_ok && tec_reg != '0) begin
                tec_next = tec_reg - 1'b1;
            end
            if (bus_evt_in.rx_err) begin
                if (rec_reg != cel_pkg::REC_MAX) begin
                    rec_next = rec_reg + 1'b1;
                end
            end else if (bus_evt_in.rx_ok && rec_reg != '0) begin
                rec_next = rec_reg - 1'b1;
            end
        end
        // State follows the new counts at once
        if (tec_next > cel_pkg::TEC_BUSOFF) begin
            state_next = cel_pkg::CEL_BUS_OFF;
        end else if (tec_next >= cel_pkg::TEC_PASSIVE ||
                     rec_next >= cel_pkg::REC_PASSIVE) begin
            state_next = cel_pkg::CEL_ERR_PASSIVE;
        end else begin
            state_next = cel_pkg::CEL_ERR_ACTIVE;
        end
    end

    // Confinement state, counters and link permissions
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tec_reg       <= '0;
            rec_reg       <= '0;
            rcv_reg       <= '0;
            state_reg     <= cel_pkg::CEL_ERR_ACTIVE;
            tx_enable_out <= 1'b1;
            rx_enable_out <= 1'b1;
        end else begin
            tec_reg       <= tec_next;
            rec_reg       <= rec_next;
            rcv_reg       <= rcv_next;
            state_reg     <= state_next;
            tx_enable_out <= (state_next != cel_pkg::CEL_BUS_OFF);
            rx_enable_out <= (state_next != cel_pkg::CEL_BUS_OFF);
        end
    end

    // Error flag and retransmit requests to the protocol engine
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_flag_req_out    <= 1'b0;
            err_flag_active_out <= 1'b0;
            retransmit_req_out  <= 1'b0;
        end else begin
            err_flag_req_out    <= bus_err && live;
            // Passive nodes send only passive flags
            err_flag_active_out <= bus_err && live &&
                                   (state_reg == cel_pkg::CEL_ERR_ACTIVE);
            retransmit_req_out  <= bus_evt_in.tx_err && live;
        end
    end

    // Error event pulses, each gated by its own enable
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_bus_err_out <= 1'b0;
            irq_passive_out <= 1'b0;
            irq_busoff_out  <= 1'b0;
        end else begin
            irq_bus_err_out <= ctrl_reg[cel_pkg::CTRL_IEN_ERR_BIT] &&
                               bus_err && live;
            irq_passive_out <= ctrl_reg[cel_pkg::CTRL_IEN_PASSIVE_BIT] &&
                (state_next == cel_pkg::CEL_ERR_PASSIVE) &&
                (state_reg != cel_pkg::CEL_ERR_PASSIVE);
            irq_busoff_out  <= ctrl_reg[cel_pkg::CTRL_IEN_BUSOFF_BIT] &&
                (state_next == cel_pkg::CEL_BUS_OFF) &&
                (state_reg != cel_pkg::CEL_BUS_OFF);
        end
    end

    // Receive FIFO acceptance; standard ids arrive high-aligned in id
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fifo_accept_out <= 1'b0;
        end else begin
            fifo_accept_out <= rx_id_in.valid && live &&
                ctrl_reg[cel_pkg::CTRL_FIFO_MODE_BIT] &&
                (cel_pkg::id_hit(rx_id_in, fid_a_reg, mask_a_reg) ||
                 cel_pkg::id_hit(rx_id_in, fid_b_reg, mask_b_reg));
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_lookup_index: assert property (
        (s_axi_arvalid_in && s_axi_arready_out && !do_write &&
         s_axi_araddr_in == cel_pkg::OFF_LOOKUP) |=>
        s_axi_rdata_out[7:0] == $past(lookup_reg[15:8]))
        else $error("lookup byte index wrong");
    a_lookup_bitsel: assert property (
        (s_axi_arvalid_in && s_axi_arready_out && !do_write &&
         s_axi_araddr_in == cel_pkg::OFF_LOOKUP) |=>
        s_axi_rdata_out[15:8] == (8'h01 << $past(lookup_reg[7:5])))
        else $error("lookup bit select wrong");
    a_tec_increment: assert property (
        (bus_evt_in.tx_err && live) |=> tec_reg == $past(tec_reg) + 9'h001)
        else $error("transmit counter did not count up");
    a_tec_decrement: assert property (
        (bus_evt_in.tx_ok && !bus_evt_in.tx_err && live && tec_reg != '0)
        |=> tec_reg == $past(tec_reg) - 9'h001)
        else $error("transmit counter did not count down");
    a_passive_level: assert property (
        (state_reg == cel_pkg::CEL_ERR_PASSIVE) |->
        ((tec_reg >= 9'h080 || rec_reg >= 8'h80) && tec_reg <= 9'h0FF))
        else $error("passive state with wrong counts");
    a_busoff_entry: assert property (
        (tec_reg > 9'h0FF) |-> (state_reg == cel_pkg::CEL_BUS_OFF))
        else $error("no bus-off above limit");
    a_busoff_silent: assert property (
        (state_reg == cel_pkg::CEL_BUS_OFF) |->
        (!tx_enable_out && !rx_enable_out) ##1 !fifo_accept_out)
        else $error("bus-off node still active");
    a_busoff_recover: assert property (
        (state_reg == cel_pkg::CEL_BUS_OFF && !sreset_reg &&
         bus_evt_in.recessive11 && rcv_reg == 8'h7F) |=>
        (state_reg == cel_pkg::CEL_ERR_ACTIVE && tec_reg == '0))
        else $error("recovery did not return to active");
    a_passive_flag: assert property (
        (bus_err && state_reg == cel_pkg::CEL_ERR_PASSIVE && !sreset_reg)
        |=> (err_flag_req_out && !err_flag_active_out))
        else $error("passive node sent active flag");
    a_err_irq: assert property (
        (bus_err && live && ctrl_reg[cel_pkg::CTRL_IEN_ERR_BIT]) |=>
        irq_bus_err_out)
        else $error("bus error interrupt missing");
    a_passive_irq: assert property (
        ($rose(state_reg == cel_pkg::CEL_ERR_PASSIVE) &&
         $past(ctrl_reg[cel_pkg::CTRL_IEN_PASSIVE_BIT])) |->
        irq_passive_out)
        else $error("passive interrupt not with state");

    c_enter_passive: cover property (
        $rose(state_reg == cel_pkg::CEL_ERR_PASSIVE));
    c_enter_busoff:  cover property (
        $rose(state_reg == cel_pkg::CEL_BUS_OFF));
    c_recover:       cover property (
        $fell(state_reg == cel_pkg::CEL_BUS_OFF));
    c_fifo_accept:   cover property (fifo_accept_out);

endmodule : cel_top

// File: dv/cel_node_model.sv
`timescale 1ns/100ps
// Far-side nodes: one register stage, no kinder than a real engine
module cel_node_model (
    input  wire logic                     clk_in,
    input  wire logic                     rst_n_in,
    input  wire cel_pkg::cel_bus_evt_type evt_in,
    input  wire cel_pkg::cel_rx_id_type   id_in,
    output cel_pkg::cel_bus_evt_type      evt_out,
    output cel_pkg::cel_rx_id_type        id_out
);
    // Requests are passed through unchanged, one cycle later
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            evt_out <= '0;
            id_out  <= '0;
        end else begin
            evt_out <= evt_in;
            id_out  <= id_in;
        end
    end
endmodule : cel_node_model

// File: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic ref_clk_in = 0, rst_n_in = 0, s_axi_awvalid_in = 0;
    logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
    logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, rd;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic s_axi_wvalid_in = 0, s_axi_bready_in = 0, s_axi_arvalid_in = 0;
    logic s_axi_rready_in = 0, s_axi_awready_out, s_axi_wready_out;
    logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rr, br;
    cel_pkg::cel_bus_evt_type ev = '0, bus_evt_in;
    cel_pkg::cel_rx_id_type rq = '0, rx_id_in;
    logic err_flag_req_out, err_flag_active_out, retransmit_req_out;
    logic tx_enable_out, rx_enable_out, irq_bus_err_out;
    logic irq_passive_out, irq_busoff_out, fifo_accept_out;
    logic [10:0] id;
    bit [7:0] tbl [256];
    int n_errors = 0, comparisons = 0, np = 0, nb = 0, na = 0, nf = 0;
    int ne = 0, nq = 0, nr = 0, seed = 32'h56AC;
    always #5 ref_clk_in = ~ref_clk_in;
    cel_top dut_u (.ref_clk_in, .rst_n_in, .s_axi_awaddr_in,
        .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
        .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
        .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
        .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
        .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
        .s_axi_rready_in, .bus_evt_in, .rx_id_in, .err_flag_req_out,
        .err_flag_active_out, .retransmit_req_out, .tx_enable_out,
        .rx_enable_out, .irq_bus_err_out, .irq_passive_out,
        .irq_busoff_out, .fifo_accept_out);
    cel_node_model node_u (.clk_in(ref_clk_in), .rst_n_in, .evt_in(ev),
        .id_in(rq), .evt_out(bus_evt_in), .id_out(rx_id_in));
    // Pulse counters: a doubled or missing pulse changes the total
    always @(posedge ref_clk_in) begin
        np += (irq_passive_out === 1'h1);
        nb += (irq_busoff_out === 1'h1);
        na += (fifo_accept_out === 1'h1);
        ne += (irq_bus_err_out === 1'h1);
        nf += (err_flag_req_out & err_flag_active_out) === 1'h1;
        nq += (err_flag_req_out === 1'h1);
        nr += (retransmit_req_out === 1'h1);
    end
    task chk(input logic [33:0] s, input logic [33:0] e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %0t seen %h want %h", $time, s, e);
        end
    endtask : chk
    task complete_run;
        if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    // Write: each channel dropped once taken, bready held until bvalid
    task wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'h1;
        s_axi_wvalid_in <= 1'h1;
        s_axi_bready_in <= 1'h1;
        do begin
            @(posedge ref_clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
        end while (s_axi_bvalid_out !== 1'h1);
        br = s_axi_bresp_out;
        s_axi_bready_in <= 1'h0;
    endtask : wr
    task rdr(input logic [7:0] a);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'h1;
        s_axi_rready_in <= 1'h1;
        do begin
            @(posedge ref_clk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
        end while (s_axi_rvalid_out !== 1'h1);
        rd = s_axi_rdata_out;
        rr = s_axi_rresp_out;
        s_axi_rready_in <= 1'h0;
    endtask : rdr
    // n back-to-back event pulses, then let the pipeline settle
    task pulse(input cel_pkg::cel_bus_evt_type e, input int n);
        repeat (n) begin
            ev <= e;
            @(posedge ref_clk_in);
        end
        ev <= '0;
        repeat (2) @(posedge ref_clk_in);
        rdr(8'h08);
    endtask : pulse
    task frm(input logic [30:0] x);
        rq <= {1'h1, x};
        @(posedge ref_clk_in);
        rq <= '0;
        repeat (3) @(posedge ref_clk_in);
    endtask : frm
    function automatic logic [31:0] est(input int t, input int r);
        return ((t > 255) ? 4 : (t > 127 || r > 127) ? 2 : 1) | t << 8 | r << 24;
    endfunction : est
    initial begin
        #100000 n_errors++;
        complete_run;
    end
    initial begin
        repeat (16) @(posedge ref_clk_in);
        rst_n_in <= 1'h1;
        @(posedge ref_clk_in);
        rdr(8'h08);
        chk(rd, est(0, 0));
        // Table marks id 0x123 as the only frame of interest
        tbl[8'h24] = 8'h08;
        for (int i = 0; i < 6; i++) begin
            id = (i < 2) ? {11{i[0]}} :
                 (i == 2) ? 11'h123 : 11'($random(seed));
            wr(8'h00, {id, 5'h00});
            rdr(8'h00);
            chk(rd, {16'h0, 8'h1 << id[2:0], id[10:3]});
            chk(|(tbl[rd[7:0]] & rd[15:8]), id == 11'h123);
        end
        wr(8'h04, 32'hF);
        pulse(5'h10, 127);
        chk(rd, est(127, 0));
        chk(np, 0);
        pulse(5'h10, 1);
        chk(rd, est(128, 0));
        chk(np, 1);
        pulse(5'h04, 1);
        pulse(5'h08, 3);
        pulse(5'h02, 1);
        chk(rd, est(127, 2));
        pulse(5'h10, 129);
        chk(rd, est(256, 2));
        chk(nb, 1);
        chk(np, 2);
        chk({tx_enable_out, rx_enable_out}, 0);
        chk(ne, 260);
        chk(nf, 132);
        chk(nq, 260);
        chk(nr, 257);
        pulse(5'h11, 127);
        chk(rd, est(256, 2));
        pulse(5'h01, 1);
        chk({tx_enable_out, rd}, {2'h1, est(0, 0)});
        wr(8'h0C, 32'h048C0000);
        wr(8'h14, 32'h1FFFFFFF);
        chk(br, 2'h0);
        wr(8'h10, 32'h40000000);
        frm({2'h0, 11'h123, 18'h0});
        frm({2'h0, 11'h124, 18'h0});
        frm({2'h1, 11'h124, 18'h5});
        chk(na, 2);
        rdr(8'h40);
        chk({rr, rd}, {2'h2, 32'h0});
        wr(8'h40, 32'h1);
        chk(br, 2'h2);
        pulse(5'h10, 256);
        chk(rd, est(256, 0));
        chk(nb, 2);
        wr(8'h04, 32'h1F);
        rdr(8'h08);
        chk(rd, est(0, 0));
        complete_run;
    end
endmodule : testbench
